/* File: pbo_port_b.sv */
`timescale 1ns/10ps
`include "pbo_params.svh"
// Functional notes
// - Plain pull-up when input, one, no disable
// - Override enable gives pull-up its value
// - Driver enable follows override or direction
// - Override value switches driver regardless
// - Driven level from override or output bit
// - Override value wins over output bit
// - Toggle override inverts the output bit
// - Input enable from sleep state or override
// - Input override ignores sleep state
// - Sense line taken before the synchroniser
// - Analog line bypasses digital path
// - Pull-up disable bit kills plain pull-ups
// - Serial slave forces clock pin input unless stage 0 drives it
// - Serial master keeps clock direction bit
// - Forced clock input keeps pull-up control
// - Serial clock, data pins on Port B
// - Capture and interrupt pins on Port B
// - Power-stage outputs on Port B
// - Direction one is output, zero input
// - Sample bit write one toggles output
// - Sleep clamps inputs unless overridden
module pbo_port_b #(
   parameter int AW = 8
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Generic override enables and values from peripherals
   input wire logic [7:0] pullup_override_en,
   input wire logic [7:0] pullup_override_val,
   input wire logic [7:0] dir_override_en,
   input wire logic [7:0] dir_override_val,
   input wire logic [7:0] value_override_en,
   input wire logic [7:0] value_override_val,
   input wire logic [7:0] toggle_override_en,
   input wire logic [7:0] input_en_override_en,
   input wire logic [7:0] input_en_override_val,
   // Sleep controller clamp request
   input wire logic sleep_clamp,
   // Serial interface, power-stage and interrupt-enable state
   input wire logic spi_en,
   input wire logic spi_master,
   input wire logic spi_sck_out,
   input wire logic stage0_en1,
   input wire logic stage0_out1,
   input wire logic stage1_en1,
   input wire logic stage1_out1,
   input wire logic stage2_en1,
   input wire logic stage2_out1,
   input wire logic stage2_en0,
   input wire logic stage2_out0,
   input wire logic ext_irq1_en,
   input wire logic ext_irq2_en,
   // Pads
   input wire logic [7:0] pad_in,
   output logic [7:0] pad_out,
   output logic [7:0] pad_oe_n,
   output logic [7:0] pad_pullup_en,
   // Unsynchronised sense lines to peripherals
   output logic [7:0] alt_sense_in
);

   // Map is fixed to one eight-pin port
   if (AW < 8)
   begin : g_chk
      $error("pbo_port_b: AW must be at least 8");
   end

   pbo_pkg::pbo_state_t s;
   pbo_pkg::pbo_state_t n;
   logic [7:0] m_pu_oe, m_pu_ov, m_dd_oe, m_dd_ov;
   logic [7:0] m_pv_oe, m_pv_ov, m_die_oe, m_die_ov;
   logic [7:0] pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov, die_oe, die_ov;
   logic [7:0] pu_eff, oe_eff, val_eff, die_eff, pin_sync;
   logic wr_go;
   logic [7:0] wr_addr;
   logic [7:0] rd_addr;

   // Alternate map of this port
   pbo_pb_altmap u_map (
      .spi_en(spi_en),
      .spi_master(spi_master),
      .spi_pin_select(s.mcu[`PBO_MCU_SPS]),
      .spi_sck_out(spi_sck_out),
      .pb7_output_bit(s.outv[`PBO_PB_SCK]),
      .global_pullup_off(s.mcu[`PBO_MCU_PUD]),
      .stage0_en1(stage0_en1),
      .stage0_out1(stage0_out1),
      .stage1_en1(stage1_en1),
      .stage1_out1(stage1_out1),
      .stage2_en1(stage2_en1),
      .stage2_out1(stage2_out1),
      .stage2_en0(stage2_en0),
      .stage2_out0(stage2_out0),
      .ext_irq1_en(ext_irq1_en),
      .ext_irq2_en(ext_irq2_en),
      .m_pu_oe(m_pu_oe),
      .m_pu_ov(m_pu_ov),
      .m_dd_oe(m_dd_oe),
      .m_dd_ov(m_dd_ov),
      .m_pv_oe(m_pv_oe),
      .m_pv_ov(m_pv_ov),
      .m_die_oe(m_die_oe),
      .m_die_ov(m_die_ov)
   );

   // merge peripheral override pairs
   // A stray value without its enable must not leak into the map
   assign pu_oe = pullup_override_en | m_pu_oe;
   assign pu_ov = (pullup_override_en & pullup_override_val)
      | (~pullup_override_en & m_pu_ov);
   assign dd_oe = dir_override_en | m_dd_oe;
   assign dd_ov = (dir_override_en & dir_override_val)
      | (~dir_override_en & m_dd_ov);
   assign pv_oe = value_override_en | m_pv_oe;
   assign pv_ov = (value_override_en & value_override_val)
      | (~value_override_en & m_pv_ov);
   assign die_oe = input_en_override_en | m_die_oe;
   assign die_ov = (input_en_override_en & input_en_override_val)
      | (~input_en_override_en & m_die_ov);

   // Per-pin override equations
   for (genvar i = 0; i < `PBO_NPIN; i++)
   begin : g_pin
      assign pu_eff[i] = pu_oe[i] ? pu_ov[i] :
         (~s.dir[i] & s.outv[i] & ~s.mcu[`PBO_MCU_PUD]);
      assign oe_eff[i] = dd_oe[i] ? dd_ov[i] : s.dir[i];
      assign val_eff[i] = pv_oe[i] ? pv_ov[i] : s.outv[i];
      assign die_eff[i] = die_oe[i] ? die_ov[i] : ~sleep_clamp;
   end

   assign alt_sense_in = pad_in & die_eff;
   // analog line joins at the pad, not here

   // Port's own sample path
   pbo_sync2 #(
      .W(`PBO_NPIN)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(alt_sense_in),
      .q(pin_sync)
   );

   assign rd_addr = {s_axi_araddr[7:2], 2'b00};

   // Next state: bus slave, port registers, pad flops
   always_comb
   begin
      n = s;
      wr_go = 1'b0;
      // Write completion handshake
      if (s.bvalid && s_axi_bready)
      begin
         n.bvalid = 1'b0;
      end
      // Address and data accepted in either order
      if (s_axi_awvalid && s.awready)
      begin
         n.aw_full = 1'b1;
         n.awaddr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s.wready)
      begin
         n.w_full = 1'b1;
         n.wdata = s_axi_wdata[7:0];
         n.wlane0 = s_axi_wstrb[0];
      end
      // Decode from the held address, no loop through a net
      wr_addr = {n.awaddr[7:2], 2'b00};
      wr_go = n.aw_full && n.w_full && !n.bvalid;
      // software toggle path shares the write
      if (wr_go)
      begin
         n.aw_full = 1'b0;
         n.w_full = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = `PBO_RESP_OKAY;
         case (wr_addr)
            `PBO_OFF_MCU:
               if (n.wlane0)
                  n.mcu = n.wdata & `PBO_MCU_WMASK;
            `PBO_OFF_DIR:
               if (n.wlane0)
                  n.dir = n.wdata;
            `PBO_OFF_OUT:
               if (n.wlane0)
                  n.outv = n.wdata;
            `PBO_OFF_PIN:
               if (n.wlane0)
                  n.outv = s.outv ^ n.wdata;
            default:
               n.bresp = `PBO_RESP_SLVERR;
         endcase
      end
      // peripheral toggle on top of any write
      n.outv = n.outv ^ toggle_override_en;
      // Read channel, one outstanding read
      if (s.rvalid && s_axi_rready)
      begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s.arready)
      begin
         n.rvalid = 1'b1;
         n.rresp = `PBO_RESP_OKAY;
         n.rdata = '0;
         case (rd_addr)
            `PBO_OFF_MCU: n.rdata[7:0] = s.mcu;
            `PBO_OFF_DIR: n.rdata[7:0] = s.dir;
            `PBO_OFF_OUT: n.rdata[7:0] = s.outv;
            `PBO_OFF_PIN: n.rdata[7:0] = pin_sync;
            default: n.rresp = `PBO_RESP_SLVERR;
         endcase
      end
      // Ready drops while a channel holds its item
      n.awready = !n.aw_full && !n.bvalid;
      n.wready = !n.w_full && !n.bvalid;
      n.arready = !n.rvalid;
      // Pad drive registered to keep outputs glitch free
      n.pad_out = val_eff;
      n.pad_oe_n = ~oe_eff;
      n.pad_pu = pu_eff;
   end

   // reset leaves a plain tri-stated port
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s <= '0;
         s.pad_oe_n <= '1;
      end
      else
      begin
         s <= n;
      end
   end

   // Outputs straight from the state flops
   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rresp = s.rresp;
   assign s_axi_rdata = s.rdata;
   assign pad_out = s.pad_out;
   assign pad_oe_n = s.pad_oe_n;
   assign pad_pullup_en = s.pad_pu;

   // Checks on the pad and bus behaviour
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_both_in;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_resp;
      s_axi_bvalid && !s_axi_awready && !s_axi_wready;
   endsequence

   property p_plain_pu;
      (pu_oe == 8'h00 && !s.mcu[`PBO_MCU_PUD])
         |=> pad_pullup_en == (~$past(s.dir) & $past(s.outv));
   endproperty
   a_plain_pu: assert property (p_plain_pu)
      else $error("plain pull-up not enabled");

   property p_pu_ovr;
      pu_oe != 8'h00
         |=> ((pad_pullup_en ^ $past(pu_ov)) & $past(pu_oe)) == 8'h00;
   endproperty
   a_pu_ovr: assert property (p_pu_ovr)
      else $error("pull-up override value not followed");

   property p_pud;
      (s.mcu[`PBO_MCU_PUD] && pu_oe == 8'h00) |=> pad_pullup_en == 8'h00;
   endproperty
   a_pud: assert property (p_pud)
      else $error("pull-up on while disabled");

   property p_dir_ovr;
      dd_oe != 8'h00
         |=> ((pad_oe_n ^ ~$past(dd_ov)) & $past(dd_oe)) == 8'h00;
   endproperty
   a_dir_ovr: assert property (p_dir_ovr)
      else $error("driver override not followed");

   property p_val_ovr;
      pv_oe != 8'h00
         |=> ((pad_out ^ $past(pv_ov)) & $past(pv_oe)) == 8'h00;
   endproperty
   a_val_ovr: assert property (p_val_ovr)
      else $error("value override not followed");

   property p_sck_slave;
      (spi_en && !spi_master && s.mcu[`PBO_MCU_SPS] && !stage0_en1
         && !dir_override_en[`PBO_PB_SCK]) |=> pad_oe_n[`PBO_PB_SCK];
   endproperty
   a_sck_slave: assert property (p_sck_slave)
      else $error("clock pin driven in slave mode");

   property p_toggle;
      (toggle_override_en[0] && !wr_go) |=> s.outv[0] != $past(s.outv[0]);
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("toggle override did not invert");

   property p_die_off;
      (die_oe[`PBO_PB_IRQ1] && !die_ov[`PBO_PB_IRQ1])
         |-> !alt_sense_in[`PBO_PB_IRQ1];
   endproperty
   a_die_off: assert property (p_die_off)
      else $error("input not disabled by override");

   property p_sleep;
      (sleep_clamp && die_oe == 8'h00) |-> alt_sense_in == 8'h00;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("sleep clamp not applied");

   property p_wr_resp;
      s_both_in |=> s_resp;
   endproperty
   a_wr_resp: assert property (p_wr_resp)
      else $error("write response late");

endmodule : pbo_port_b

/* File: pbo_params.svh */
`ifndef PBO_PARAMS_SVH
`define PBO_PARAMS_SVH

// Register byte offsets
`define PBO_OFF_MCU 8'h00
`define PBO_OFF_DIR 8'h04
`define PBO_OFF_OUT 8'h08
`define PBO_OFF_PIN 8'h0C

// Control register field positions
`define PBO_MCU_SPS 7
`define PBO_MCU_PUD 4
`define PBO_MCU_VTS 1
`define PBO_MCU_VCE 0
// Writable bits of the control register
`define PBO_MCU_WMASK 8'h93
`define PBO_MCU_RST 8'h00

// Port B pin positions
`define PBO_PB_SCK 7
`define PBO_PB_ICP 6
`define PBO_PB_IRQ2 5
`define PBO_PB_IRQ1 2
`define PBO_PB_MOSI 1
`define PBO_PB_MISO 0

// Bus answers
`define PBO_RESP_OKAY 2'h0
`define PBO_RESP_SLVERR 2'h2
`define PBO_NPIN 8

`endif

/* File: pbo_pkg.sv */
package pbo_pkg;

   // Register state of the port block outside its input synchroniser
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_full;
      logic [7:0] awaddr;
      logic w_full;
      logic [7:0] wdata;
      logic wlane0;
      logic [7:0] mcu;
      logic [7:0] dir;
      logic [7:0] outv;
      logic [7:0] pad_out;
      logic [7:0] pad_oe_n;
      logic [7:0] pad_pu;
   } pbo_state_t;

endpackage : pbo_pkg

/* File: pbo_sync2.sv */
`timescale 1ns/10ps
module pbo_sync2 #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Asynchronous level in, synchronised level out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_q;

   // A zero-width bus leaves nothing to synchronise
   if (W < 1)
   begin : g_chk
      $error("pbo_sync2: W must be at least 1");
   end

   // Two stages per bit; the first stage feeds only the second
   for (genvar i = 0; i < W; i++)
   begin : g_bit
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            meta_q[i] <= 1'b0;
            q[i] <= 1'b0;
         end
         else
         begin
            meta_q[i] <= d[i];
            q[i] <= meta_q[i];
         end
      end
   end

endmodule : pbo_sync2

/* File: pbo_pb_altmap.sv */
`timescale 1ns/10ps
`include "pbo_params.svh"
module pbo_pb_altmap (
   // Serial interface state
   input wire logic spi_en,
   input wire logic spi_master,
   input wire logic spi_pin_select,
   input wire logic spi_sck_out,
   // Port state used by the pull-up override
   input wire logic pb7_output_bit,
   input wire logic global_pullup_off,
   // Power-stage enables and levels
   input wire logic stage0_en1,
   input wire logic stage0_out1,
   input wire logic stage1_en1,
   input wire logic stage1_out1,
   input wire logic stage2_en1,
   input wire logic stage2_out1,
   input wire logic stage2_en0,
   input wire logic stage2_out0,
   // External interrupt enables
   input wire logic ext_irq1_en,
   input wire logic ext_irq2_en,
   // Generated override pairs
   output logic [7:0] m_pu_oe,
   output logic [7:0] m_pu_ov,
   output logic [7:0] m_dd_oe,
   output logic [7:0] m_dd_ov,
   output logic [7:0] m_pv_oe,
   output logic [7:0] m_pv_ov,
   output logic [7:0] m_die_oe,
   output logic [7:0] m_die_ov
);

   logic spi_slave;
   logic spi_mst;

   // Serial pins only act when routed to this port
   assign spi_slave = spi_en & ~spi_master & spi_pin_select;
   assign spi_mst = spi_en & spi_master & spi_pin_select;

   // Fixed per-pin alternate map, unused pins stay zero
   always_comb
   begin
      m_pu_oe = '0;
      m_pu_ov = '0;
      m_dd_oe = '0;
      m_dd_ov = '0;
      m_pv_oe = '0;
      m_pv_ov = '0;
      m_die_oe = '0;
      m_die_ov = '0;
      m_dd_oe[`PBO_PB_SCK] = spi_slave | stage0_en1;
      m_dd_ov[`PBO_PB_SCK] = stage0_en1;
      m_pu_oe[`PBO_PB_SCK] = spi_slave & ~stage0_en1;
      m_pu_ov[`PBO_PB_SCK] = pb7_output_bit & ~global_pullup_off;
      m_pv_oe[`PBO_PB_SCK] = spi_mst | stage0_en1;
      m_pv_ov[`PBO_PB_SCK] = stage0_en1 ? stage0_out1 : spi_sck_out;
      m_dd_oe[`PBO_PB_ICP] = stage1_en1;
      m_dd_ov[`PBO_PB_ICP] = 1'b1;
      m_pv_oe[`PBO_PB_ICP] = stage1_en1;
      m_pv_ov[`PBO_PB_ICP] = stage1_out1;
      m_dd_oe[`PBO_PB_MOSI] = stage2_en1;
      m_dd_ov[`PBO_PB_MOSI] = 1'b1;
      m_pv_oe[`PBO_PB_MOSI] = stage2_en1;
      m_pv_ov[`PBO_PB_MOSI] = stage2_out1;
      m_dd_oe[`PBO_PB_MISO] = stage2_en0;
      m_dd_ov[`PBO_PB_MISO] = 1'b1;
      m_pv_oe[`PBO_PB_MISO] = stage2_en0;
      m_pv_ov[`PBO_PB_MISO] = stage2_out0;
      m_die_oe[`PBO_PB_IRQ2] = ext_irq2_en;
      m_die_ov[`PBO_PB_IRQ2] = ext_irq2_en;
      m_die_oe[`PBO_PB_IRQ1] = ext_irq1_en;
      m_die_ov[`PBO_PB_IRQ1] = ext_irq1_en;
   end

endmodule : pbo_pb_altmap

/* File: pbo_pad_model.sv */
`timescale 1ns/10ps
// Pads plus one consumer of the sense lines
module pbo_pad_model (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Port side of the pads, plus the outside source level
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe_n,
   input wire logic [7:0] pad_pullup_en,
   input wire logic [7:0] ext_lvl,
   output logic [7:0] pad_in,
   // Sense lines and their synchronised copy
   input wire logic [7:0] alt_sense_in,
   output logic [7:0] sense_sync
);
   logic [7:0] meta_q;

   // Own driver wins, else pull-up or the outside source
   assign pad_in = (~pad_oe_n & pad_out) |
                   (pad_oe_n & (pad_pullup_en | ext_lvl));

   // consumer synchronises sense
   // Two flops, since the port hands the line over raw
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_q <= 8'h00;
         sense_sync <= 8'h00;
      end
      else
      begin
         meta_q <= alt_sense_in;
         sense_sync <= meta_q;
      end
   end
endmodule : pbo_pad_model

/* File: test_port_pin_alternate_override.sv */
`timescale 1ns/10ps
`include "pbo_params.svh"
module test_port_pin_alternate_override;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb, st_en, st_out;
   logic [1:0] bresp, rresp, resp;
   logic [7:0] pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov, tog, ie_oe, ie_ov;
   logic sleep, spi_en, spi_mst, irq1, irq2, sck;
   logic [7:0] pad_in, pad_out, oe_n, pu, alt, sync, ext;
   int failures, samples_checked, i;
   // Row: dir out mcu pu_oe pu_ov dd_oe dd_ov pv_oe pv_ov | oe_n out pu
   localparam logic [95:0] ROWS [5] = '{
      96'hF0CC00_000000_000000_0FC00C,
      96'hF0CC10_000000_000000_0FC000,
      96'hF0CC10_0F0500_000000_0FC005,
      96'hF0CC00_3C003C_0F0000_33CC00,
      96'hFFCC00_000000_000F0A_00CA00};

   // Free-running clock
   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   pbo_port_b #(.AW(8)) pbo_port_b_i (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pullup_override_en(pu_oe), .pullup_override_val(pu_ov),
      .dir_override_en(dd_oe), .dir_override_val(dd_ov),
      .value_override_en(pv_oe), .value_override_val(pv_ov),
      .toggle_override_en(tog), .input_en_override_en(ie_oe),
      .input_en_override_val(ie_ov), .sleep_clamp(sleep),
      .spi_en(spi_en), .spi_master(spi_mst), .spi_sck_out(sck),
      .stage0_en1(st_en[3]), .stage0_out1(st_out[3]),
      .stage1_en1(st_en[2]), .stage1_out1(st_out[2]),
      .stage2_en1(st_en[1]), .stage2_out1(st_out[1]),
      .stage2_en0(st_en[0]), .stage2_out0(st_out[0]),
      .ext_irq1_en(irq1), .ext_irq2_en(irq2), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe_n(oe_n), .pad_pullup_en(pu),
      .alt_sense_in(alt));

   pbo_pad_model pbo_pad_model_i (
      .aclk(aclk), .aresetn(aresetn), .pad_out(pad_out),
      .pad_oe_n(oe_n), .pad_pullup_en(pu), .ext_lvl(ext),
      .pad_in(pad_in), .alt_sense_in(alt), .sense_sync(sync));

   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Verdict and end of run
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test

   // Let edges pass, then sample settled outputs
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask : tick

   // Bus write; address and data offered together
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      logic aw_on, w_on, b_on;
      aw_on = 1'b1;
      w_on = 1'b1;
      b_on = 1'b1;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // Local flags, since the driven values lag by one update
      for (n = 0; n < 50 && (aw_on || w_on || b_on); n++)
      begin
         @(posedge aclk);
         if (aw_on && awready)
         begin
            aw_on = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_on && wready)
         begin
            w_on = 1'b0;
            wvalid <= 1'b0;
         end
         if (b_on && bvalid)
         begin
            b_on = 1'b0;
            resp = bresp;
            bready <= 1'b0;
         end
      end
      if (aw_on || w_on || b_on)
      begin
         failures++;
         stop_test();
      end
   endtask : wr

   // Bus read
   task automatic rdr(input logic [7:0] a);
      int n;
      logic ar_on, r_on;
      ar_on = 1'b1;
      r_on = 1'b1;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50 && (ar_on || r_on); n++)
      begin
         @(posedge aclk);
         if (ar_on && arready)
         begin
            ar_on = 1'b0;
            arvalid <= 1'b0;
         end
         if (r_on && rvalid)
         begin
            r_on = 1'b0;
            rd = rdata;
            resp = rresp;
            rready <= 1'b0;
         end
      end
      if (ar_on || r_on)
      begin
         failures++;
         stop_test();
      end
   endtask : rdr

   // Main sequence
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata, wstrb} = 52'h0000000000000 | 4'hF;
      {pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov, tog, ie_oe, ie_ov} = 72'h0;
      {sleep, spi_en, spi_mst, irq1, irq2, st_en, st_out} = 13'h0;
      ext = 8'h00;
      sck = 1'b0;
      failures = 0;
      samples_checked = 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      tick(2);
      chk(32'(oe_n), 32'h000000FF);
      chk(32'(pu), 32'h00000000);
      rdr(8'h00);
      chk(rd, 32'h00000000);
      wr(8'h00, 8'hFF);
      rdr(8'h00);
      chk(rd, 32'h00000093);
      wr(8'h10, 8'hFF);
      chk(32'(resp), 32'(`PBO_RESP_SLVERR));
      rdr(8'h10);
      chk(32'(resp), 32'(`PBO_RESP_SLVERR));
      $display("Test reset and registers done");
      for (i = 0; i < 5; i++)
      begin
         wr(8'h04, ROWS[i][95:88]);
         wr(8'h08, ROWS[i][87:80]);
         wr(8'h00, ROWS[i][79:72]);
         @(posedge aclk);
         {pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov} <= ROWS[i][71:24];
         tick(2);
         chk(32'(oe_n), 32'(ROWS[i][23:16]));
         chk(32'(pad_out & ~ROWS[i][23:16]), 32'(ROWS[i][15:8]));
         chk(32'(pu), 32'(ROWS[i][7:0]));
      end
      @(posedge aclk);
      {pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov} <= 48'h0;
      $display("Test override rows done");
      // Peripherals hand in their own toggle and enable pairs
      wr(8'h08, 8'h00);
      @(posedge aclk);
      tog <= 8'h81;
      @(posedge aclk);
      tog <= 8'h00;
      rdr(8'h08);
      chk(rd, 32'h00000081);
      chk(32'(pad_out), 32'h00000081);
      wr(8'h0C, 8'h03);
      rdr(8'h08);
      chk(rd, 32'h00000082);
      $display("Test toggles done");
      wr(8'h04, 8'h00);
      wr(8'h08, 8'h00);
      @(posedge aclk);
      ext <= 8'hFF;
      tick(3);
      chk(32'(alt), 32'h000000FF);
      chk(32'(sync), 32'h000000FF);
      rdr(8'h0C);
      chk(rd, 32'h000000FF);
      @(posedge aclk);
      sleep <= 1'b1;
      tick(2);
      chk(32'(alt), 32'h00000000);
      @(posedge aclk);
      ie_oe <= 8'h0F;
      ie_ov <= 8'h05;
      tick(2);
      chk(32'(alt), 32'h00000005);
      @(posedge aclk);
      ie_oe <= 8'h00;
      irq1 <= 1'b1;
      irq2 <= 1'b1;
      tick(2);
      chk(32'(alt), 32'h00000024);
      @(posedge aclk);
      {sleep, irq1, irq2, ie_ov, ext} <= 19'h0;
      $display("Test input enables done");
      wr(8'h00, 8'h80);
      wr(8'h04, 8'hFF);
      wr(8'h08, 8'h80);
      @(posedge aclk);
      spi_en <= 1'b1;
      dd_ov <= 8'h80;
      tick(2);
      chk(32'(oe_n[7]), 32'h00000001);
      chk(32'(pu[7]), 32'h00000001);
      @(posedge aclk);
      spi_mst <= 1'b1;
      tick(2);
      chk(32'(oe_n[7]), 32'h00000000);
      chk(32'(pad_out[7]), 32'h00000000);
      @(posedge aclk);
      sck <= 1'b1;
      tick(2);
      chk(32'(pad_out[7]), 32'h00000001);
      @(posedge aclk);
      spi_en <= 1'b0;
      dd_ov <= 8'h00;
      sck <= 1'b0;
      wr(8'h00, 8'h00);
      wr(8'h04, 8'h00);
      @(posedge aclk);
      st_en <= 4'hF;
      st_out <= 4'hF;
      tick(2);
      chk(32'(oe_n), 32'h0000003C);
      chk(32'(pad_out & 8'hC3), 32'h000000C3);
      @(posedge aclk);
      st_en <= 4'h0;
      $display("Test serial and power stage done");
      // Reset again in mid-run
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      tick(1);
      chk(32'(oe_n), 32'h000000FF);
      rdr(8'h08);
      chk(rd, 32'h00000000);
      $display("Test second reset done");
      stop_test();
   end
endmodule : test_port_pin_alternate_override
